/* common/pss_consts.vh */
// Purpose: constants for the two-wire slave front end of the dual pot
// Assumes: 100 MHz mclk_i; serial clock sampled, never used as a clock
// Notes: timing counts derived from times in their own units
// Overview of operation
// - programming cycle after write stop, at most 5 ms
// - busy: data released, address ignored
// - data changes only while clock low
// - start is falling data, clock high
// - stop is rising data, clock high
// - master clocks; device never drives clock
// - address upper nibble type, lower nibble pins
// - receiver acknowledges on ninth clock pulse
// - acknowledge address and every written byte
// - read: send byte, check ack, continue
// - write is address, instruction, data, stop
// - program only stored-register writes; ignore meanwhile
// - busy withholds ack; ack again when done
// - instruction upper nibble is the opcode
// - pot select bit picks wiper register
// - low two bits pick stored setting
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH
`define PSS_CLK_PERIOD_NS     10
`define PSS_PROG_TIME_MS      5
`define PSS_PROG_CYCLES       ((`PSS_PROG_TIME_MS * 1000000) / `PSS_CLK_PERIOD_NS)
`define PSS_PWRUP_TIME_MS     1
`define PSS_PWRUP_CYCLES      ((`PSS_PWRUP_TIME_MS * 1000000) / `PSS_CLK_PERIOD_NS)
`define PSS_TYPE_ID           4'h9 // arbitrary type identifier
`define PSS_ADDR_TYPE_MSB     7
`define PSS_ADDR_TYPE_LSB     4
`define PSS_OPC_MSB           7
`define PSS_OPC_LSB           4
`define PSS_POT_BIT           2
`define PSS_SET_MSB           1
`define PSS_SET_LSB           0
`define PSS_OPC_WR_DATA       4'hC
`define PSS_OPC_WCR_TO_DR     4'hE
`define PSS_OPC_GLB_WCR_TO_DR 4'h8
`define PSS_READ_BIT          0
`endif

/* hw/pss_shift_reg.v */
// Purpose: byte shifter for the serial front end, registered output
// Assumes: shift and load are one-cycle enables on mclk_i
// Notes: msb first, as the two-wire bus sends it
`timescale 1ns/10ps
module pss_shift_reg (
  input  wire       mclk_i,
  input  wire       resetn_i,
  input  wire       shift_i,
  input  wire       bit_i,
  input  wire       load_i,
  input  wire [7:0] load_data_i,
  output reg  [7:0] data_o
);
  // load wins over shift
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_o <= 8'h00;
    end else if (load_i) begin
      data_o <= load_data_i;
    end else if (shift_i) begin
      data_o <= {data_o[6:0], bit_i};
    end
  end
endmodule

/* hw/pss_slave.v */
// Purpose: two-wire slave front end, address match, ack, busy period
// Assumes: scl and sda from pins, synchronised here on mclk_i
// Notes: instruction execution is outside; fields are presented as ports
`timescale 1ns/10ps
`include "pss_consts.vh"
module pss_slave #(
  parameter PROG_CYCLES  = `PSS_PROG_CYCLES,
  parameter PWRUP_CYCLES = `PSS_PWRUP_CYCLES
) (
  input  wire       mclk_i,
  input  wire       resetn_i,
  input  wire       scl_i,
  input  wire       sda_i,
  input  wire       addr_select_pin_bit0_i,
  input  wire       addr_select_pin_bit1_i,
  input  wire       addr_select_pin_bit2_i,
  input  wire       addr_select_pin_bit3_i,
  input  wire [7:0] read_data_i,
  output reg        sda_o,
  output reg        sda_oe_n_o,
  output reg  [3:0] opcode_o,
  output reg        pot_select_bit_o,
  output reg        setting_select_hi_o,
  output reg        setting_select_lo_o,
  output reg  [7:0] wr_data_o,
  output reg        wr_strobe_o,
  output reg        rd_strobe_o,
  output reg        busy_o,
  output reg        ready_o
);
  // one-hot states
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_RX   = 7'h02;
  localparam [6:0] ST_ACK  = 7'h04;
  localparam [6:0] ST_TX   = 7'h08;
  localparam [6:0] ST_RACK = 7'h10;
  localparam [6:0] ST_WAIT = 7'h20;
  localparam [6:0] ST_NACK = 7'h40;
  localparam [22:0] PROG_CNT  = PROG_CYCLES;
  localparam [22:0] PWRUP_CNT = PWRUP_CYCLES;

  // two-stage synchronisers; first stage read by nothing else
  reg        scl_s1_reg;
  reg        scl_s2_reg;
  reg        scl_d_reg;
  reg        sda_s1_reg;
  reg        sda_s2_reg;
  reg        sda_d_reg;
  reg  [3:0] pin_s1_reg;
  reg  [3:0] pin_s2_reg;
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg  <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg  <= 1'b1;
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
    end else begin
      scl_s1_reg <= scl_i;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg  <= scl_s2_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg  <= sda_s2_reg;
      pin_s1_reg <= {addr_select_pin_bit3_i, addr_select_pin_bit2_i,
                     addr_select_pin_bit1_i, addr_select_pin_bit0_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // bus events on the synchronised lines
  wire scl_rise = scl_s2_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s2_reg & scl_d_reg;
  wire start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  wire stop_det  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  // true when an opcode writes nonvolatile storage
  function nv_write;
    input [3:0] opc;
    begin
      nv_write = (opc == `PSS_OPC_WR_DATA) | (opc == `PSS_OPC_WCR_TO_DR) |
                 (opc == `PSS_OPC_GLB_WCR_TO_DR);
    end
  endfunction

  reg  [6:0]  state_reg;
  reg  [6:0]  state_next;
  reg  [3:0]  bit_cnt_reg;
  reg  [1:0]  byte_idx_reg;
  reg         read_mode_reg;
  reg         nv_pend_reg;
  reg         ack_ok_reg;
  reg  [22:0] prog_cnt_reg;
  reg  [22:0] pwr_cnt_reg;
  wire [7:0]  shift_q;

  // receive shifts on rising scl; transmit loads then shifts on falling
  wire rx_shift = (state_reg == ST_RX) & scl_rise;
  wire tx_shift = (state_reg == ST_TX) & scl_fall & (bit_cnt_reg != 4'h7);
  // first byte loads only at the fall that ends the ninth clock
  wire tx_load  = (((state_reg == ST_ACK) & (bit_cnt_reg == 4'h9)) | (state_reg == ST_RACK)) &
                  scl_fall & read_mode_reg & ack_ok_reg;

  pss_shift_reg u_shift (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .shift_i     (rx_shift | tx_shift),
    .bit_i       (sda_s2_reg),
    .load_i      (tx_load),
    .load_data_i (read_data_i),
    .data_o      (shift_q)
  );

  // byte received as complete at the eighth rising edge
  wire [7:0] rx_byte = {shift_q[6:0], sda_s2_reg};
  wire       addr_match = (rx_byte[`PSS_ADDR_TYPE_MSB:`PSS_ADDR_TYPE_LSB] == `PSS_TYPE_ID) &
                          (rx_byte[3:0] == pin_s2_reg);
  wire       rx_last = rx_shift & (bit_cnt_reg == 4'h7);
  wire       can_ack = ~busy_o & ready_o;

  // power-up hold-off, stands in for the master's wait
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_cnt_reg <= 23'h00_0000;
      ready_o     <= 1'b0;
    end else if (!ready_o) begin
      pwr_cnt_reg <= pwr_cnt_reg + 23'h00_0001;
      ready_o     <= (pwr_cnt_reg >= PWRUP_CNT - 23'h00_0001);
    end
  end

  // programming cycle timer
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prog_cnt_reg <= 23'h00_0000;
      busy_o       <= 1'b0;
    end else if (busy_o) begin
      prog_cnt_reg <= prog_cnt_reg + 23'h00_0001;
      if (prog_cnt_reg >= PROG_CNT - 23'h00_0001) begin
        busy_o <= 1'b0;
      end
    end else if (stop_det & nv_pend_reg) begin
      prog_cnt_reg <= 23'h00_0000;
      busy_o       <= 1'b1;
    end
  end

  // next-state logic
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = ST_IDLE;
      ST_RX: begin
        if (rx_last) begin
          if (byte_idx_reg == 2'd0 && !(addr_match && can_ack)) begin
            state_next = ST_NACK;
          end else begin
            state_next = ST_ACK;
          end
        end
      end
      ST_ACK: begin
        // leave only after the ninth clock, in both directions
        if (scl_fall && bit_cnt_reg == 4'h9) begin
          state_next = read_mode_reg ? ST_TX : ST_RX;
        end
      end
      ST_TX: begin
        if (scl_fall && bit_cnt_reg == 4'h7) begin
          state_next = ST_RACK;
        end
      end
      ST_RACK: begin
        if (scl_rise) begin
          state_next = sda_s2_reg ? ST_WAIT : ST_RACK;
        end else if (scl_fall) begin
          state_next = ST_TX;
        end
      end
      ST_WAIT: state_next = ST_WAIT;
      ST_NACK: state_next = ST_NACK;
      default: state_next = ST_IDLE;
    endcase
    if (start_det) begin
      state_next = ST_RX;
    end else if (stop_det) begin
      state_next = ST_IDLE;
    end
  end

  // sequence registers
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      byte_idx_reg  <= 2'd0;
      read_mode_reg <= 1'b0;
      nv_pend_reg   <= 1'b0;
      ack_ok_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start_det) begin
        bit_cnt_reg  <= 4'h0;
        byte_idx_reg <= 2'd0;
        nv_pend_reg  <= 1'b0;
      end else if (stop_det) begin
        nv_pend_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_RX: begin
            if (rx_shift) begin
              bit_cnt_reg <= rx_last ? 4'h8 : bit_cnt_reg + 4'h1;
            end
            if (rx_last && byte_idx_reg == 2'd0) begin
              read_mode_reg <= rx_byte[`PSS_READ_BIT];
              ack_ok_reg    <= 1'b1;
            end
            if (rx_last && byte_idx_reg == 2'd2) begin
              nv_pend_reg <= nv_write(opcode_o);
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                bit_cnt_reg <= 4'h9;
              end else begin
                bit_cnt_reg  <= 4'h0;
                byte_idx_reg <= (byte_idx_reg == 2'd3) ? 2'd3 : byte_idx_reg + 2'd1;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              ack_ok_reg <= ~sda_s2_reg;
            end
            if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
            end
          end
          default: bit_cnt_reg <= bit_cnt_reg;
        endcase
      end
    end
  end

  // captured fields and strobes toward the pot logic
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opcode_o            <= 4'h0;
      pot_select_bit_o    <= 1'b0;
      setting_select_hi_o <= 1'b0;
      setting_select_lo_o <= 1'b0;
      wr_data_o           <= 8'h00;
      wr_strobe_o         <= 1'b0;
      rd_strobe_o         <= 1'b0;
    end else begin
      wr_strobe_o <= 1'b0;
      rd_strobe_o <= tx_load;
      if (rx_last && byte_idx_reg == 2'd1) begin
        opcode_o            <= rx_byte[`PSS_OPC_MSB:`PSS_OPC_LSB];
        pot_select_bit_o    <= rx_byte[`PSS_POT_BIT];
        setting_select_hi_o <= rx_byte[`PSS_SET_MSB];
        setting_select_lo_o <= rx_byte[`PSS_SET_LSB];
      end
      if (rx_last && byte_idx_reg == 2'd2) begin
        wr_data_o   <= rx_byte;
        wr_strobe_o <= 1'b1;
      end
    end
  end

  // data line drive: open drain, enable low while pulling for ack or sending a 0 bit
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sda_o      <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end else begin
      sda_o <= 1'b0;
      // pull from the eighth fall until the ninth fall, starting and ending only while scl is low
      if (state_next == ST_ACK && state_reg == ST_ACK && (bit_cnt_reg == 4'h9 || scl_fall) &&
          !start_det && !stop_det) begin
        sda_oe_n_o <= 1'b0;
      end else if (state_next == ST_TX && !start_det && !stop_det) begin
        sda_oe_n_o <= tx_load ? read_data_i[7] : shift_q[tx_shift ? 6 : 7];
      end else begin
        sda_oe_n_o <= 1'b1;
      end
    end
  end
endmodule

/* tb/pss_master_model.sv */
// Purpose: two-wire bus master for the slave front end
// Assumes: pull-up on data; 125 ns serial clock, still between frames
// Notes: open drain, so a 1 here means released
`timescale 1ns/10ps
module pss_master_model (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_bus_i
);
  localparam realtime Q = 31.25;
  // idle bus, both lines released
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task start;
    sda_o = 1'b1;
    scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
  endtask
  task stop;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask
  // data moves a quarter period after the clock falls
  task automatic bit_io(input logic b, output logic r);
    #Q sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_bus_i;
    #Q scl_o = 1'b0;
  endtask
  // byte msb first, then ninth clock carrying our own ack bit
  task automatic xfer(input logic [7:0] b, input logic mack, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(mack, ack);
  endtask
endmodule

/* tb/pss_slave_assertions.sv */
// Purpose: port-level checker for the two-wire slave front end
// Assumes: parameters match the bound instance
// Notes: bound into every pss_slave
`timescale 1ns/10ps
module pss_slave_checker #(
  parameter PROG_CYCLES  = 200,
  parameter PWRUP_CYCLES = 50
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic wr_strobe_o,
  input wire logic rd_strobe_o,
  input wire logic busy_o,
  input wire logic ready_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  int bcnt;
  int rcnt;
  // busy length and time since reset, counted for the bounds below
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bcnt <= 0;
      rcnt <= 0;
    end else begin
      bcnt <= busy_o ? bcnt + 1 : 0;
      if (rcnt < PWRUP_CYCLES) rcnt <= rcnt + 1;
    end
  end
  sequence s_ack_pull; $fell(sda_oe_n_o); endsequence
  sequence s_bus_idle; scl_i && sda_i; endsequence
  property p_prog_bound; bcnt <= PROG_CYCLES; endproperty
  property p_busy_quiet; busy_o |-> sda_oe_n_o; endproperty
  property p_hold_off; (rcnt < PWRUP_CYCLES - 2) |-> !ready_o && sda_oe_n_o; endproperty
  property p_scl_low_change; $changed(sda_oe_n_o) |-> !scl_i; endproperty
  property p_open_drain; !sda_oe_n_o |-> !sda_o; endproperty
  property p_ack_stands; s_ack_pull |-> !sda_oe_n_o [*6]; endproperty
  property p_ack_legal; s_ack_pull |-> ready_o && !busy_o; endproperty
  property p_wr_pulse; wr_strobe_o |=> !wr_strobe_o; endproperty
  property p_rd_pulse; rd_strobe_o |=> !rd_strobe_o; endproperty
  property p_prog_at_stop; $rose(busy_o) |-> s_bus_idle; endproperty
  a_prog_bound: assert property (p_prog_bound) else $error("busy too long");
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
  a_hold_off: assert property (p_hold_off) else $error("early ready");
  a_scl_low_change: assert property (p_scl_low_change) else $error("data moved, clock high");
  a_open_drain: assert property (p_open_drain) else $error("drove high");
  a_ack_stands: assert property (p_ack_stands) else $error("ack too short");
  a_ack_legal: assert property (p_ack_legal) else $error("ack while busy");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe long");
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe long");
  a_prog_at_stop: assert property (p_prog_at_stop) else $error("busy not at stop");
endmodule
bind pss_slave pss_slave_checker #(.PROG_CYCLES(PROG_CYCLES), .PWRUP_CYCLES(PWRUP_CYCLES)) pss_slave_checker_inst (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .wr_strobe_o(wr_strobe_o), .rd_strobe_o(rd_strobe_o),
  .busy_o(busy_o), .ready_o(ready_o));

/* tb/tb_pss_slave.sv */
// Purpose: self-checking bench for the two-wire slave front end
// Assumes: short programming and power-up counts
// Notes: pins and read data change on the falling clock edge
`timescale 1ns/10ps
`include "pss_consts.vh"
module tb_pss_slave;
  logic       mclk_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [7:0] rd_byte = 8'h00;
  logic [7:0] r;
  logic [7:0] ins;
  logic       a;
  wire        m_scl, m_sda, sda_o, sda_oe_n_o, wr_strobe_o, rd_strobe_o, busy_o, ready_o, pot, shi, slo;
  wire  [3:0] opcode_o;
  wire  [7:0] wr_data_o;
  wire        sda_bus = m_sda & (sda_oe_n_o | sda_o);
  wire  [7:0] adr = {`PSS_TYPE_ID, pins};
  logic [3:0] ops [4] = '{`PSS_OPC_WR_DATA, `PSS_OPC_WCR_TO_DR, `PSS_OPC_GLB_WCR_TO_DR, 4'hA};
  int         failures = 0;
  int         tests_run = 0;
  int         i;
  int         j;
  pss_master_model pss_master_model_inst (.scl_o(m_scl), .sda_o(m_sda), .sda_bus_i(sda_bus));
  pss_slave #(.PROG_CYCLES(200), .PWRUP_CYCLES(50)) pss_slave_inst (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .scl_i(m_scl), .sda_i(sda_bus),
    .addr_select_pin_bit0_i(pins[0]), .addr_select_pin_bit1_i(pins[1]),
    .addr_select_pin_bit2_i(pins[2]), .addr_select_pin_bit3_i(pins[3]),
    .read_data_i(rd_byte), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .opcode_o(opcode_o),
    .pot_select_bit_o(pot), .setting_select_hi_o(shi), .setting_select_lo_o(slo),
    .wr_data_o(wr_data_o), .wr_strobe_o(wr_strobe_o), .rd_strobe_o(rd_strobe_o),
    .busy_o(busy_o), .ready_o(ready_o));
  initial forever #5 mclk_i = ~mclk_i;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ack polling: start, address, stop
  task poll(output logic ack);
    pss_master_model_inst.start();
    pss_master_model_inst.xfer(adr, 1'b1, r, ack);
    pss_master_model_inst.stop();
  endtask
  // watchdog far beyond the expected run
  initial begin
    #500000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i) resetn_i = 1'b1;
    for (j = 0; j < 200 && ready_o !== 1'b1; j++) @(negedge mclk_i);
    check({7'h00, ready_o}, 8'h01, "ready after hold-off");
    @(negedge mclk_i) pins = 4'b1010;
    // foreign addresses: each pin bit and a type bit flipped
    for (i = 0; i < 5; i++) begin
      pss_master_model_inst.start();
      pss_master_model_inst.xfer(adr ^ (8'h01 << i), 1'b1, r, a);
      check({7'h00, a}, 8'h01, "foreign address acked");
      pss_master_model_inst.stop();
    end
    $display("test address match done");
    // writes across the opcode table and every setting select
    for (i = 0; i < 4; i++) begin
      ins = {ops[i], 1'b0, i[0], i[1:0]};
      pss_master_model_inst.start();
      pss_master_model_inst.xfer(adr, 1'b1, r, a);
      check({7'h00, a}, 8'h00, "address ack");
      pss_master_model_inst.xfer(ins, 1'b1, r, a);
      check({7'h00, a}, 8'h00, "instruction ack");
      pss_master_model_inst.xfer(8'h30 + i[7:0], 1'b1, r, a);
      check({7'h00, a}, 8'h00, "data ack");
      pss_master_model_inst.stop();
      repeat (5) @(negedge mclk_i);
      check({opcode_o, 1'b0, pot, shi, slo}, ins, "instruction fields");
      check(wr_data_o, 8'h30 + i[7:0], "write data");
      check({7'h00, busy_o}, {7'h00, i < 3}, "programming start");
      if (i < 3) begin
        poll(a);
        check({7'h00, a}, 8'h01, "ack while busy");
        for (j = 0; j < 10 && a; j++) poll(a);
        check({7'h00, a}, 8'h00, "no ack after programming");
      end
    end
    $display("test writes done");
    // read: first byte acked, second refused by the master
    @(negedge mclk_i) pins = 4'b1011;
    rd_byte = 8'hA5;
    repeat (5) @(negedge mclk_i);
    pss_master_model_inst.start();
    pss_master_model_inst.xfer(adr, 1'b1, r, a);
    check({7'h00, a}, 8'h00, "read address ack");
    pss_master_model_inst.xfer(8'hFF, 1'b0, r, a);
    check(r, 8'hA5, "first read byte");
    pss_master_model_inst.xfer(8'hFF, 1'b1, r, a);
    check(r, 8'hA5, "second read byte");
    repeat (10) @(negedge mclk_i);
    check({7'h00, sda_oe_n_o}, 8'h01, "released after refusal");
    pss_master_model_inst.stop();
    $display("test read done");
    print_verdict();
  end
endmodule
